// file: frtc_top.sv
// Operation
// - With the ignore bit set, the io-supply and core-supply overvoltage flags have no effect.
// - With the reload bit set, a restart after shutdown first downloads the nonvolatile setup; cleared, it does not.
// - The supply overvoltage debounce before shutdown is 500 us with the debounce bit set and 2 us with it cleared.
// - An accurate overcurrent flag on either channel acts only after the delay chosen by the three-bit delay field.
// - After a shutdown the supply restarts only after the reenable delay chosen by the two-bit field.
// - With blank bit 7 set, both rectifier drives stay off until soft start ends.
// - With blank bit 6 set, the overtemperature flag is ignored until soft start ends.
// - With blank bit 5 set, the external fault input is ignored until soft start ends.
// - With blank bit 4 set, the local overvoltage flag is ignored until soft start ends.
// - With blank bit 3 set, the load overvoltage flag is ignored until soft start ends.
// - With blank bit 2 set, the second channel accurate overcurrent flag is ignored until soft start ends.
// - With blank bit 1 set, the first channel accurate overcurrent flag is ignored until soft start ends.
// - With blank bit 0 set, the first channel fast overcurrent flag is ignored until soft start ends.
// - A fault not held off re-enables the supply by itself once cleared, after the reenable delay.
//
// The address-and-strobe port was decided locally.
module frtc_top import frtc_pkg::*; #(
  parameter logic [TMR_W-1:0] OV_DEB_LONG_CYC = frtc_us_cyc(OV_DEB_LONG_US),
  parameter logic [TMR_W-1:0] OCP_DLY_CYC [8] = '{
    frtc_us_cyc(OCP_DLY_US[0]), frtc_us_cyc(OCP_DLY_US[1]), frtc_us_cyc(OCP_DLY_US[2]),
    frtc_us_cyc(OCP_DLY_US[3]), frtc_us_cyc(OCP_DLY_US[4]), frtc_us_cyc(OCP_DLY_US[5]),
    frtc_us_cyc(OCP_DLY_US[6]), frtc_us_cyc(OCP_DLY_US[7])},
  parameter logic [TMR_W-1:0] REEN_DLY_CYC [4] = '{
    frtc_us_cyc(REEN_DLY_MS[0] * 1000), frtc_us_cyc(REEN_DLY_MS[1] * 1000),
    frtc_us_cyc(REEN_DLY_MS[2] * 1000), frtc_us_cyc(REEN_DLY_MS[3] * 1000)}
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // fault flags from the monitors
  input wire logic IO_SUPPLY_OVERVOLTAGE,
  input wire logic CORE_SUPPLY_OVERVOLTAGE,
  input wire logic CURRENT_SENSE_FIRST_FAST_OCP,
  input wire logic CURRENT_SENSE_FIRST_ACC_OCP,
  input wire logic CURRENT_SENSE_SECOND_ACC_OCP,
  input wire logic LOAD_OVERVOLTAGE_PROTECTION,
  input wire logic LOCAL_OVERVOLTAGE_PROTECTION,
  input wire logic EXTERNAL_FAULT_INPUT,
  input wire logic OVERTEMPERATURE,
  // restart control
  input wire logic FAULT_HOLD_OFF,
  input wire logic SUPPLY_RESTART,
  input wire logic SOFTSTART_DONE,
  input wire logic NVM_LOAD_DONE,
  // power stage control
  output logic POWER_OFF,
  output logic SYNC_RECTIFIER_DRIVE_A_EN,
  output logic SYNC_RECTIFIER_DRIVE_B_EN,
  output logic NVM_RELOAD_REQ
);
  logic [1:0] rst_sync_ff;
  logic rst_n;
  frtc_cfg_if cfg ();
  frtc_state_t state_ff;
  frtc_state_t nxt_state;
  logic off_ff;
  logic nxt_off;
  logic sr_ff;
  logic nxt_sr;
  logic [6:0] flt_raw;
  logic [6:0] flt_qual;
  logic blank_active;
  logic running;
  logic ov_any;
  logic ov_run;
  logic ov_exp;
  logic ocp_run;
  logic ocp_exp;
  logic reen_exp;
  logic imm_fault;
  logic trip;
  logic fault_present;
  logic [TMR_W-1:0] ov_limit;
  logic [TMR_W-1:0] ocp_limit;
  logic [TMR_W-1:0] reen_limit;
  logic [7:0] status;

  // reset release through two flip-flops
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  frtc_regs u_regs (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .addr(REG_ADDR),
    .wdata(REG_WDATA),
    .wr(REG_WR),
    .rd(REG_RD),
    .rdata(REG_RDATA),
    .status(status),
    .cfg(cfg.regs)
  );

  // blanking window is the soft-start state itself
  assign blank_active = (state_ff == ST_SOFT);
  assign running = (state_ff == ST_SOFT) || (state_ff == ST_RUN);

  assign flt_raw = {OVERTEMPERATURE, EXTERNAL_FAULT_INPUT, LOCAL_OVERVOLTAGE_PROTECTION,
                    LOAD_OVERVOLTAGE_PROTECTION, CURRENT_SENSE_SECOND_ACC_OCP,
                    CURRENT_SENSE_FIRST_ACC_OCP, CURRENT_SENSE_FIRST_FAST_OCP};

  // per-flag soft-start blanking
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BLANKABLE; gi++) begin : g_blank
      assign flt_qual[gi] = flt_raw[gi] && !(blank_active && cfg.blank_cfg[gi]); // to
      blank_mask_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n) // to
        (blank_active && cfg.blank_cfg[gi] && (flt_raw == (7'h01 << gi)) && !ov_run) |=> !POWER_OFF)
        else $error("blanked flag shut the supply during soft start");
    end
  endgenerate

  // supply overvoltage path and its debounce
  assign ov_any = !cfg.flag_cfg[OV_IGNORE_BIT] && (IO_SUPPLY_OVERVOLTAGE || CORE_SUPPLY_OVERVOLTAGE);
  assign ov_run = running && ov_any;
  assign ov_limit = cfg.flag_cfg[OV_DEB_BIT] ? OV_DEB_LONG_CYC : OV_DEB_SHORT_CYC;

  frtc_timer u_ov_tmr (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .run(ov_run),
    .limit(ov_limit),
    .expired(ov_exp)
  );

  // accurate overcurrent delay, shared by both channels
  assign ocp_run = running && (flt_qual[ACC_CS1_IDX] || flt_qual[ACC_CS2_IDX]);
  assign ocp_limit = OCP_DLY_CYC[cfg.flag_cfg[OCP_DLY_LSB +: OCP_DLY_W]];

  frtc_timer u_ocp_tmr (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .run(ocp_run),
    .limit(ocp_limit),
    .expired(ocp_exp)
  );

  // reenable delay after shutdown
  assign reen_limit = REEN_DLY_CYC[cfg.flag_cfg[REEN_LSB +: REEN_W]];

  frtc_timer u_reen_tmr (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .run(state_ff == ST_REEN),
    .limit(reen_limit),
    .expired(reen_exp)
  );

  assign imm_fault = |(flt_qual & IMM_MASK);
  assign trip = running && (imm_fault || ov_exp || ocp_exp);
  assign fault_present = (|flt_raw) || ov_any;

  // supply sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_SOFT: begin
        if (trip) begin
          nxt_state = ST_SHUT;
        end else if (SOFTSTART_DONE) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (trip) begin
          nxt_state = ST_SHUT;
        end
      end
      ST_SHUT: begin
        if (!fault_present && (!FAULT_HOLD_OFF || SUPPLY_RESTART)) begin
          nxt_state = ST_REEN;
        end
      end
      ST_REEN: begin
        if (reen_exp) begin
          nxt_state = cfg.flag_cfg[OV_RELOAD_BIT] ? ST_LOAD : ST_SOFT;
        end
      end
      ST_LOAD: begin
        if (NVM_LOAD_DONE) begin
          nxt_state = ST_SOFT;
        end
      end
      default: nxt_state = ST_SHUT;
    endcase
    nxt_off = (nxt_state == ST_SHUT) || (nxt_state == ST_REEN) || (nxt_state == ST_LOAD);
    nxt_sr = (nxt_state == ST_RUN) || ((nxt_state == ST_SOFT) && !cfg.blank_cfg[BLANK_SR_BIT]);
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_SOFT;
      off_ff <= 1'b0;
      sr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      off_ff <= nxt_off;
      sr_ff <= nxt_sr;
    end
  end

  assign POWER_OFF = off_ff;
  assign SYNC_RECTIFIER_DRIVE_A_EN = sr_ff;
  assign SYNC_RECTIFIER_DRIVE_B_EN = sr_ff;
  assign NVM_RELOAD_REQ = (state_ff == ST_LOAD);
  assign status = {sr_ff, off_ff, blank_active, ocp_run, ov_run, state_ff};

  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!rst_n);

  sequence ov_short_start_s;
    $rose(ov_run) && !cfg.flag_cfg[OV_DEB_BIT] && !cfg.flag_cfg[OV_IGNORE_BIT];
  endsequence

  sequence reen_done_s;
    (state_ff == ST_REEN) && reen_exp;
  endsequence

  ov_ignore_a: assert property (
    (cfg.flag_cfg[OV_IGNORE_BIT] && (state_ff == ST_RUN) && !imm_fault && !ocp_exp) |=> (state_ff == ST_RUN))
    else $error("supply overvoltage acted while ignored");

  ov_short_hold_a: assert property (
    ov_short_start_s |-> !ov_exp [*8])
    else $error("short debounce expired too early");

  ov_short_fire_a: assert property (
    ($rose(ov_exp) && !cfg.flag_cfg[OV_DEB_BIT] && $stable(cfg.flag_cfg)) |-> $past(ov_run, 100))
    else $error("short debounce not 100 cycles");

  ocp_trip_a: assert property (
    (ocp_exp && running) |=> (state_ff == ST_SHUT) && POWER_OFF)
    else $error("accurate overcurrent delay did not shut down");

  reen_wait_a: assert property (
    ((state_ff == ST_REEN) && !reen_exp) |=> (state_ff == ST_REEN) && POWER_OFF)
    else $error("restart before reenable delay");

  reload_path_a: assert property (
    reen_done_s |=> ($past(cfg.flag_cfg[OV_RELOAD_BIT]) ? (state_ff == ST_LOAD) && NVM_RELOAD_REQ : (state_ff == ST_SOFT)))
    else $error("wrong restart path after reenable delay");

  sr_blank_a: assert property (
    ((state_ff == ST_SOFT) && $past(cfg.blank_cfg[BLANK_SR_BIT])) |-> !SYNC_RECTIFIER_DRIVE_A_EN && !SYNC_RECTIFIER_DRIVE_B_EN)
    else $error("rectifier drive on while blanked");

  auto_reen_a: assert property (
    ((state_ff == ST_SHUT) && !fault_present && !FAULT_HOLD_OFF) |=> (state_ff == ST_REEN) ##1 POWER_OFF)
    else $error("cleared fault did not start reenable delay");

  softstart_end_a: assert property (
    ((state_ff == ST_SOFT) && SOFTSTART_DONE && !trip) |=> (state_ff == ST_RUN) && !blank_active)
    else $error("blanking not lifted at soft-start end");

  imm_trip_a: assert property (
    (running && imm_fault) |=> POWER_OFF && !SYNC_RECTIFIER_DRIVE_A_EN)
    else $error("immediate fault did not shut down");

  ocp_hold_a: assert property (
    $rose(ocp_run) |-> !ocp_exp [*8])
    else $error("overcurrent delay expired too early");

  ov_long_hold_a: assert property (
    ($rose(ov_run) && cfg.flag_cfg[OV_DEB_BIT]) |-> !ov_exp [*8])
    else $error("long debounce expired too early");

  load_hold_a: assert property (
    ((state_ff == ST_LOAD) && !NVM_LOAD_DONE) |=> (state_ff == ST_LOAD) && POWER_OFF && NVM_RELOAD_REQ)
    else $error("restart before download finished");

  shut_hold_a: assert property (
    ((state_ff == ST_SHUT) && fault_present) |=> (state_ff == ST_SHUT) && POWER_OFF)
    else $error("reenable started while fault present");

  hold_wait_a: assert property (
    ((state_ff == ST_SHUT) && FAULT_HOLD_OFF && !SUPPLY_RESTART) |=> (state_ff == ST_SHUT))
    else $error("held-off fault reenabled without restart");

  sr_run_a: assert property (
    (state_ff == ST_RUN) |-> SYNC_RECTIFIER_DRIVE_A_EN && SYNC_RECTIFIER_DRIVE_B_EN)
    else $error("rectifier drive off after soft start");

  flag_write_a: assert property (
    (REG_WR && (REG_ADDR == FLAG_CFG_OFS)) |=> (cfg.flag_cfg == $past(REG_WDATA)))
    else $error("flag configuration write lost");

  blank_write_a: assert property (
    (REG_WR && (REG_ADDR == BLANK_CFG_OFS)) |=> (cfg.blank_cfg == $past(REG_WDATA)))
    else $error("blanking write lost");

  rdata_idle_a: assert property (
    !$past(REG_RD) |-> (REG_RDATA == 8'h00))
    else $error("read data outside its cycle");
endmodule

// file: frtc_pkg.sv
package frtc_pkg;
  // register map
  localparam logic [7:0] FLAG_CFG_OFS = 8'h0E;
  localparam logic [7:0] BLANK_CFG_OFS = 8'h0F;
  localparam logic [7:0] STATUS_OFS = 8'h30;
  localparam logic [7:0] FLAG_CFG_RST = 8'h00;
  localparam logic [7:0] BLANK_CFG_RST = 8'h00;

  // flag configuration fields
  localparam int unsigned OV_IGNORE_BIT = 7;
  localparam int unsigned OV_RELOAD_BIT = 6;
  localparam int unsigned OV_DEB_BIT = 5;
  localparam int unsigned OCP_DLY_LSB = 2;
  localparam int unsigned OCP_DLY_W = 3;
  localparam int unsigned REEN_LSB = 0;
  localparam int unsigned REEN_W = 2;

  // blanking fields; bits 6..0 follow the order of the blankable fault vector
  localparam int unsigned BLANK_SR_BIT = 7;
  localparam int unsigned NUM_BLANKABLE = 7;
  localparam int unsigned FAST_CS1_IDX = 0;
  localparam int unsigned ACC_CS1_IDX = 1;
  localparam int unsigned ACC_CS2_IDX = 2;
  // faults that shut down at once, their own debounce being done upstream
  localparam logic [6:0] IMM_MASK = 7'h79;

  // timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned TMR_W = 28;
  localparam int unsigned OV_DEB_SHORT_US = 2;
  localparam int unsigned OV_DEB_LONG_US = 500;
  localparam int unsigned OCP_DLY_US [8] = '{1300, 13000, 130000, 260000, 600000, 1300000, 2000000, 2600000};
  localparam int unsigned REEN_DLY_MS [4] = '{500, 1000, 2000, 4000};
  localparam logic [TMR_W-1:0] OV_DEB_SHORT_CYC = TMR_W'(OV_DEB_SHORT_US * CLK_MHZ);

  function automatic logic [TMR_W-1:0] frtc_us_cyc(input int unsigned us);
    return TMR_W'(us * CLK_MHZ);
  endfunction

  // gray coded along soft -> run -> shut -> reenable -> reload
  typedef enum logic [2:0] {
    ST_SOFT = 3'h0,
    ST_RUN = 3'h1,
    ST_SHUT = 3'h3,
    ST_REEN = 3'h2,
    ST_LOAD = 3'h6
  } frtc_state_t;
endpackage

// file: frtc_cfg_if.sv
interface frtc_cfg_if;
  logic [7:0] flag_cfg;
  logic [7:0] blank_cfg;
  modport regs (output flag_cfg, output blank_cfg);
  modport core (input flag_cfg, input blank_cfg);
endinterface

// file: frtc_timer.sv
module frtc_timer import frtc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [TMR_W-1:0] limit,
  // result
  output logic expired
);
  logic [TMR_W-1:0] cnt_ff;
  logic [TMR_W-1:0] nxt_cnt;

  // counts cycles while run is high, restarts whenever run drops
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!run) begin
      nxt_cnt = '0;
    end else if (cnt_ff < limit) begin
      nxt_cnt = cnt_ff + TMR_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign expired = run && (cnt_ff >= limit);
endmodule

// file: frtc_regs.sv
module frtc_regs import frtc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // block state
  input wire logic [7:0] status,
  frtc_cfg_if.regs cfg
);
  logic [7:0] flag_ff;
  logic [7:0] blank_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_flag;
  logic [7:0] nxt_blank;
  logic [7:0] nxt_rdata;

  // writes to unmapped offsets are dropped, unmapped reads return zero
  always_comb begin
    nxt_flag = flag_ff;
    nxt_blank = blank_ff;
    nxt_rdata = 8'h00;
    if (wr && addr == FLAG_CFG_OFS) begin
      nxt_flag = wdata;
    end
    if (wr && addr == BLANK_CFG_OFS) begin
      nxt_blank = wdata;
    end
    if (rd) begin
      case (addr)
        FLAG_CFG_OFS: nxt_rdata = flag_ff;
        BLANK_CFG_OFS: nxt_rdata = blank_ff;
        STATUS_OFS: nxt_rdata = status;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= FLAG_CFG_RST;
      blank_ff <= BLANK_CFG_RST;
      rdata_ff <= 8'h00;
    end else begin
      flag_ff <= nxt_flag;
      blank_ff <= nxt_blank;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;
  assign cfg.flag_cfg = flag_ff;
  assign cfg.blank_cfg = blank_ff;
endmodule

// file: frtc_far_model.sv
module frtc_far_model #(
  parameter int RAMP = 20,
  parameter int LOAD = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stage state
  input wire logic hold,
  input wire logic power_off,
  input wire logic reload_req,
  // answers
  output logic softstart_done,
  output logic load_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int ramp_cnt;
  int load_cnt;
  // ramp restarts on any shutdown, its end is a level held until then
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_cnt <= 0;
      softstart_done <= 1'b0;
    end else if (power_off || reload_req || hold) begin
      ramp_cnt <= 0;
      softstart_done <= 1'b0;
    end else if (ramp_cnt < RAMP) begin
      ramp_cnt <= ramp_cnt + 1;
    end else begin
      softstart_done <= 1'b1;
    end
  end
  // download answers only while it is asked for
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n || !reload_req) begin
      load_cnt <= 0;
      load_done <= 1'b0;
    end else if (load_cnt < LOAD) begin
      load_cnt <= load_cnt + 1;
    end else begin
      load_done <= 1'b1;
    end
  end
endmodule

// file: fault_response_timing_config_tb_top.sv
module fault_response_timing_config_tb_top;
  import frtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [TMR_W-1:0] OCP_P [8] = '{28'h14, 28'h28, 28'h3C, 28'h50, 28'h64, 28'h78, 28'h8C, 28'hA0};
  localparam logic [TMR_W-1:0] REEN_P [4] = '{28'h1E, 28'h3C, 28'h5A, 28'h78};
  localparam int RAMP = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [8:0] flt = 9'h000;
  logic hold_off = 1'b0;
  logic restart = 1'b0;
  logic hold = 1'b1;
  logic saw_req = 1'b0;
  logic [7:0] rdata;
  logic ss_done, ld_done, po, sr_a, sr_b, rl_req;
  int err_count = 0;
  int n_compared = 0;

  always #10 clk = ~clk;
  always @(posedge clk) if (rl_req === 1'b1) saw_req <= 1'b1;

  frtc_top #(.OV_DEB_LONG_CYC(28'hC8), .OCP_DLY_CYC(OCP_P), .REEN_DLY_CYC(REEN_P)) uut (
    .CLK_SYS(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
    .REG_RDATA(rdata), .IO_SUPPLY_OVERVOLTAGE(flt[7]), .CORE_SUPPLY_OVERVOLTAGE(flt[8]),
    .CURRENT_SENSE_FIRST_FAST_OCP(flt[0]), .CURRENT_SENSE_FIRST_ACC_OCP(flt[1]),
    .CURRENT_SENSE_SECOND_ACC_OCP(flt[2]), .LOAD_OVERVOLTAGE_PROTECTION(flt[3]),
    .LOCAL_OVERVOLTAGE_PROTECTION(flt[4]), .EXTERNAL_FAULT_INPUT(flt[5]), .OVERTEMPERATURE(flt[6]),
    .FAULT_HOLD_OFF(hold_off), .SUPPLY_RESTART(restart), .SOFTSTART_DONE(ss_done), .NVM_LOAD_DONE(ld_done),
    .POWER_OFF(po), .SYNC_RECTIFIER_DRIVE_A_EN(sr_a), .SYNC_RECTIFIER_DRIVE_B_EN(sr_b), .NVM_RELOAD_REQ(rl_req));

  frtc_far_model #(.RAMP(RAMP), .LOAD(10)) far (.clk(clk), .rst_n(rst_n), .hold(hold), .power_off(po),
    .reload_req(rl_req), .softstart_done(ss_done), .load_done(ld_done));

  task wrap_up;
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic wait_po(input logic v, input int mx, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (po !== v && n < mx);
  endtask

  task automatic trip(input logic [8:0] m, output int n);
    @(posedge clk);
    flt <= m;
    wait_po(1'b1, 400, n);
  endtask

  task automatic wait_run;
    repeat (RAMP + 4) @(posedge clk);
    #1 chk(sr_a, 1'b1);
  endtask

  task automatic rec(input int r);
    int n;
    @(posedge clk);
    flt <= 9'h000;
    wait_po(1'b0, r + 10, n);
    chk(n inside {[r:r + 4]}, 1'b1);
    wait_run();
  endtask

  task t_regs;
    rd(FLAG_CFG_OFS, 8'h00);
    rd(BLANK_CFG_OFS, 8'h00);
    rd(STATUS_OFS, 8'hA0);
    wr(FLAG_CFG_OFS, 8'hA5);
    rd(FLAG_CFG_OFS, 8'hA5);
    wr(BLANK_CFG_OFS, 8'h5A);
    rd(BLANK_CFG_OFS, 8'h5A);
    wr(STATUS_OFS, 8'hFF);
    rd(STATUS_OFS, 8'hA0);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    wr(FLAG_CFG_OFS, 8'h00);
    rd(FLAG_CFG_OFS, 8'h00);
  endtask

  task automatic t_blank;
    int n;
    chk(sr_a, 1'b1);
    wr(BLANK_CFG_OFS, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      flt <= 9'(1 << i);
      repeat (30) @(posedge clk);
      #1 chk(po, 1'b0);
      chk({sr_a, sr_b}, 2'b00);
    end
    @(posedge clk);
    flt <= 9'h000;
    hold <= 1'b0;
    n = 0;
    while (ss_done !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    chk(sr_a, 1'b0);
    @(posedge clk);
    #1 chk({sr_a, sr_b}, 2'b11);
    trip(9'h040, n);
    chk(n inside {[1:2]}, 1'b1);
    rec(30);
  endtask

  task automatic t_imm;
    int n;
    wr(BLANK_CFG_OFS, 8'h00);
    for (int i = 0; i < 7; i++) if (IMM_MASK[i]) begin
      trip(9'(1 << i), n);
      chk(n inside {[1:2]}, 1'b1);
      rec(30);
    end
  endtask

  task automatic t_reen;
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(FLAG_CFG_OFS, 8'(c));
      trip(9'h010, n);
      rec(30 * (c + 1));
    end
  endtask

  task automatic t_ocp;
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(FLAG_CFG_OFS, 8'(c << 2));
      trip(c[0] ? 9'h004 : 9'h002, n);
      chk(n inside {[20 * (c + 1):20 * (c + 1) + 2]}, 1'b1);
      rec(30);
    end
  endtask

  task automatic t_ov;
    int n;
    wr(FLAG_CFG_OFS, 8'h00);
    trip(9'h080, n);
    chk(n inside {[100:102]}, 1'b1);
    rec(30);
    wr(FLAG_CFG_OFS, 8'h20);
    trip(9'h100, n);
    chk(n inside {[200:202]}, 1'b1);
    rec(30);
    wr(FLAG_CFG_OFS, 8'h80);
    trip(9'h180, n);
    chk(n, 400);
    @(posedge clk);
    flt <= 9'h000;
  endtask

  task automatic t_reload;
    int n;
    wr(FLAG_CFG_OFS, 8'h40);
    trip(9'h010, n);
    @(posedge clk);
    flt <= 9'h000;
    repeat (35) @(posedge clk);
    #1 chk({rl_req, po}, 2'b11);
    wait_po(1'b0, 40, n);
    chk(n < 40, 1'b1);
    wait_run();
    wr(FLAG_CFG_OFS, 8'h00);
    saw_req <= 1'b0;
    trip(9'h010, n);
    rec(30);
    chk(saw_req, 1'b0);
  endtask

  task automatic t_hold;
    int n;
    @(posedge clk);
    hold_off <= 1'b1;
    trip(9'h020, n);
    @(posedge clk);
    flt <= 9'h000;
    repeat (150) @(posedge clk);
    #1 chk(po, 1'b1);
    @(posedge clk);
    restart <= 1'b1;
    hold_off <= 1'b0;
    @(posedge clk);
    restart <= 1'b0;
    wait_po(1'b0, 60, n);
    chk(n inside {[28:35]}, 1'b1);
    wait_run();
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_blank();
    t_imm();
    t_reen();
    t_ocp();
    t_ov();
    t_reload();
    t_hold();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule
